// ### host_model.sv
// Host model issuing byte writes and reads on the register port.
`timescale 1ns/10ps
module host_model (
  // Clock
  input  wire logic       clk_i,
  // Read answer
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  // Register port
  output logic            wr_en_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  output logic            rd_en_o,
  output logic [7:0]      rd_addr_o
);
  initial
  begin
    wr_en_o = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 8'h00;
    rd_en_o = 1'b0;
    rd_addr_o = 8'h00;
  end

  // Released lines show the inverse so a stale value is never mistaken for a live one.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    wr_addr_o = addr;
    wr_data_o = data;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wr_addr_o = ~addr;
    wr_data_o = ~data;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(negedge clk_i);
    rd_en_o = 1'b1;
    rd_addr_o = addr;
    @(negedge clk_i);
    rd_en_o = 1'b0;
    rd_addr_o = ~addr;
    data = rd_data_i;
    valid = rd_valid_i;
  endtask
endmodule

// ### led_ctrl_pkg.sv
// Package with register map, field layout, reset values and timing constants.
package led_ctrl_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_DUTY = 8'h02;
  localparam logic [7:0] ADDR_SCAN = 8'h03;
  localparam logic [7:0] ADDR_CFG  = 8'h04;

  // ==========================================================================
  // Field layout
  localparam int CFG_RUN_BIT     = 0;
  localparam int CFG_VARIANT_BIT = 1;
  localparam int CFG_CLEAR_BIT   = 5;
  localparam int SCAN_W          = 2;
  localparam int DUTY_W          = 6;
  localparam int DIGITS          = 4;
  localparam int GROUPS          = 2 * DIGITS;

  // ==========================================================================
  // Reset values
  localparam logic              RUN_RESET  = 1'b0;
  localparam logic [SCAN_W-1:0] SCAN_RESET = 2'h3;
  localparam logic [DUTY_W-1:0] DUTY_RESET = 6'h03;
  localparam logic [7:0]        READ_NONE  = 8'h00;

  // ==========================================================================
  // PWM steps
  localparam logic [DUTY_W-1:0] STEP_FIRST = 6'h00;
  localparam logic [DUTY_W-1:0] STEP_LAST  = 6'h3f;
  localparam logic [DUTY_W-1:0] DUTY_CAP   = 6'h3e;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_TIME_NS  = 5000;
  localparam int STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Decoding
  function automatic logic [GROUPS-1:0] group_mask(input logic [SCAN_W-1:0] limit);
    logic [GROUPS-1:0] mask;
    mask = '0;
    for (int i = 0; i < DIGITS; i++)
    begin
      if (i <= int'(limit))
      begin
        mask[i]          = 1'b1;
        mask[i + DIGITS] = 1'b1;
      end
    end
    return mask;
  endfunction

  function automatic logic [DIGITS-1:0] digit_onehot(input logic [SCAN_W-1:0] digit);
    logic [DIGITS-1:0] hot;
    hot = '0;
    hot[digit] = 1'b1;
    return hot;
  endfunction

endpackage

// ### led_display_control_regs.sv
// Control registers and multiplex scan timing of the LED display driver.
`timescale 1ns/10ps
module led_display_control_regs #(
  parameter int         STEP_CYCLES = led_ctrl_pkg::STEP_CYCLES,
  parameter logic       VARIANT     = 1'b0
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rstn_i,
  // Register write port
  input  wire logic                            wr_en_i,
  input  wire logic [7:0]                      wr_addr_i,
  input  wire logic [7:0]                      wr_data_i,
  // Register read port
  input  wire logic                            rd_en_i,
  input  wire logic [7:0]                      rd_addr_i,
  output logic      [7:0]                      rd_data_o,
  output logic                                 rd_valid_o,
  output logic                                 addr_err_o,
  // Settings seen by the rest of the device
  output logic                                 shutdown_o,
  output logic [led_ctrl_pkg::SCAN_W-1:0]      scan_limit_o,
  output logic [led_ctrl_pkg::DUTY_W-1:0]      duty_o,
  output logic                                 clear_data_o,
  // Multiplex drive
  output logic [led_ctrl_pkg::DIGITS-1:0]      digit_drive_o,
  output logic [led_ctrl_pkg::GROUPS-1:0]      seg_group_en_o,
  output logic                                 seg_pwm_on_o,
  output logic [led_ctrl_pkg::GROUPS-1:0]      key_sample_en_o
);

  // ==========================================================================
  // Reset release
  // Release reaches the logic two edges late, so no flop sees a runt reset edge.
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // Register decode
  // Only three codes are mapped; every other code is refused and flagged.
  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == led_ctrl_pkg::ADDR_DUTY) || (addr == led_ctrl_pkg::ADDR_SCAN)
           || (addr == led_ctrl_pkg::ADDR_CFG);
  endfunction

  // ==========================================================================
  // Control registers
  logic                            run_reg;
  logic                            run_next;
  logic [led_ctrl_pkg::SCAN_W-1:0] scan_reg;
  logic [led_ctrl_pkg::SCAN_W-1:0] scan_next;
  logic [led_ctrl_pkg::DUTY_W-1:0] duty_reg;
  logic [led_ctrl_pkg::DUTY_W-1:0] duty_next;
  logic                            clear_reg;
  logic                            clear_next;

  always_comb
  begin
    run_next   = run_reg;
    scan_next  = scan_reg;
    duty_next  = duty_reg;
    clear_next = 1'b0;
    if (wr_en_i)
    begin
      case (wr_addr_i)
        led_ctrl_pkg::ADDR_CFG:
        begin
          // Variant bit and the ignored bits are dropped here.
          run_next   = wr_data_i[led_ctrl_pkg::CFG_RUN_BIT];
          // Clear is a one-cycle action and never reads back.
          clear_next = wr_data_i[led_ctrl_pkg::CFG_CLEAR_BIT];
        end
        led_ctrl_pkg::ADDR_SCAN:
        begin
          scan_next = wr_data_i[led_ctrl_pkg::SCAN_W-1:0];
        end
        led_ctrl_pkg::ADDR_DUTY:
        begin
          duty_next = wr_data_i[led_ctrl_pkg::DUTY_W-1:0];
        end
        default:
        begin
          run_next = run_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      run_reg   <= led_ctrl_pkg::RUN_RESET;
      scan_reg  <= led_ctrl_pkg::SCAN_RESET;
      duty_reg  <= led_ctrl_pkg::DUTY_RESET;
      clear_reg <= 1'b0;
    end
    else
    begin
      run_reg   <= run_next;
      scan_reg  <= scan_next;
      duty_reg  <= duty_next;
      clear_reg <= clear_next;
    end
  end

  // ==========================================================================
  // Shutdown flag
  // A flop of its own, so the pin never shows an inverter after the register.
  logic halt_reg;
  logic halt_next;

  always_comb
  begin
    halt_next = !run_next;
  end

  always_ff @(posedge clk_i or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      halt_reg <= !led_ctrl_pkg::RUN_RESET;
    end
    else
    begin
      halt_reg <= halt_next;
    end
  end

  // ==========================================================================
  // Read port
  // Unmapped codes read as zero; the read data holds its value between reads.
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       err_reg;
  logic       err_next;

  always_comb
  begin
    rdata_next  = rdata_reg;
    rvalid_next = rd_en_i;
    err_next    = (rd_en_i && !is_mapped(rd_addr_i)) || (wr_en_i && !is_mapped(wr_addr_i));
    if (rd_en_i)
    begin
      rdata_next = led_ctrl_pkg::READ_NONE;
      case (rd_addr_i)
        led_ctrl_pkg::ADDR_CFG:
        begin
          rdata_next[led_ctrl_pkg::CFG_RUN_BIT]     = run_reg;
          rdata_next[led_ctrl_pkg::CFG_VARIANT_BIT] = VARIANT;
        end
        led_ctrl_pkg::ADDR_SCAN:
        begin
          rdata_next[led_ctrl_pkg::SCAN_W-1:0] = scan_reg;
        end
        led_ctrl_pkg::ADDR_DUTY:
        begin
          rdata_next[led_ctrl_pkg::DUTY_W-1:0] = duty_reg;
        end
        default:
        begin
          rdata_next = led_ctrl_pkg::READ_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      rdata_reg  <= led_ctrl_pkg::READ_NONE;
      rvalid_reg <= 1'b0;
      err_reg    <= 1'b0;
    end
    else
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      err_reg    <= err_next;
    end
  end

  // ==========================================================================
  // Multiplex timing
  // While running, settings enter the timer only at a slot edge, so a rewrite never cuts a pulse.
  scan_if scan_bus ();

  logic                            seg_on;
  logic [led_ctrl_pkg::DIGITS-1:0] digit_on;
  logic [led_ctrl_pkg::GROUPS-1:0] group_on;

  slot_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .clk_i      (clk_i),
    .rst_n_i    (rst_sync_reg),
    .run_i      (run_reg),
    .scan_req_i (scan_reg),
    .duty_req_i (duty_reg),
    .sb         (scan_bus)
  );

  pwm_gate u_gate (
    .sb         (scan_bus),
    .seg_on_o   (seg_on),
    .digit_on_o (digit_on),
    .group_on_o (group_on)
  );

  // ==========================================================================
  // Drive outputs
  logic [led_ctrl_pkg::DIGITS-1:0] digit_reg;
  logic [led_ctrl_pkg::DIGITS-1:0] digit_next;
  logic [led_ctrl_pkg::GROUPS-1:0] group_reg;
  logic [led_ctrl_pkg::GROUPS-1:0] group_next;
  logic                            pwm_reg;
  logic                            pwm_next;
  logic [led_ctrl_pkg::GROUPS-1:0] key_reg;
  logic [led_ctrl_pkg::GROUPS-1:0] key_next;

  always_comb
  begin
    // Shutdown blanks everything, including the key sampling windows.
    digit_next = digit_on;
    group_next = group_on;
    pwm_next   = seg_on;
    // Keys share the segment group enables, so only digits inside the scan limit can sample them.
    key_next   = group_on;
    if (!run_reg)
    begin
      // A stopped timer already shows no slot; this keeps shutdown dark on its own.
      digit_next = '0;
      group_next = '0;
      pwm_next   = 1'b0;
      key_next   = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      digit_reg <= '0;
      group_reg <= '0;
      pwm_reg   <= 1'b0;
      key_reg   <= '0;
    end
    else
    begin
      digit_reg <= digit_next;
      group_reg <= group_next;
      pwm_reg   <= pwm_next;
      key_reg   <= key_next;
    end
  end

  assign rd_data_o       = rdata_reg;
  assign rd_valid_o      = rvalid_reg;
  assign addr_err_o      = err_reg;
  assign shutdown_o      = halt_reg;
  assign scan_limit_o    = scan_reg;
  assign duty_o          = duty_reg;
  assign clear_data_o    = clear_reg;
  assign digit_drive_o   = digit_reg;
  assign seg_group_en_o  = group_reg;
  assign seg_pwm_on_o    = pwm_reg;
  assign key_sample_en_o = key_reg;

endmodule

// ### led_display_control_regs_chk.sv
// Concurrent checks on the ports of the LED display control registers.
`timescale 1ns/10ps
module led_display_control_regs_chk #(
  parameter int   STEP_CYCLES = 2,
  parameter logic VARIANT     = 1'b0
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Register port
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       rd_en_i,
  input  wire logic [7:0] rd_addr_i,
  input  wire logic [7:0] rd_data_o,
  input  wire logic       rd_valid_o,
  input  wire logic       addr_err_o,
  // Settings and drive
  input  wire logic       shutdown_o,
  input  wire logic [1:0] scan_limit_o,
  input  wire logic [5:0] duty_o,
  input  wire logic       clear_data_o,
  input  wire logic [3:0] digit_drive_o,
  input  wire logic [7:0] seg_group_en_o,
  input  wire logic       seg_pwm_on_o,
  input  wire logic [7:0] key_sample_en_o
);
  // ==========================================================================
  // Lit-run counter
  // Counts how long segments stay lit inside driven slots without a dark step.
  logic [15:0] run_reg;
  logic [15:0] run_next;

  always_comb
    run_next = (seg_pwm_on_o && digit_drive_o != 4'h0) ? run_reg + 16'h0001 : 16'h0000;

  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      run_reg <= 16'h0000;
    else
      run_reg <= run_next;

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_cfg_write;
    wr_en_i && wr_addr_i == led_ctrl_pkg::ADDR_CFG;
  endsequence

  sequence s_cfg_read;
    rd_en_i && rd_addr_i == led_ctrl_pkg::ADDR_CFG;
  endsequence

  a_read_valid_pulse: assert property (rd_en_i |=> rd_valid_o)
    else $error("read strobe not answered");
  a_unmapped_read: assert property (rd_en_i && !(rd_addr_i inside {8'h02, 8'h03, 8'h04})
    |=> addr_err_o && rd_data_o == led_ctrl_pkg::READ_NONE) else $error("unmapped read");
  a_cfg_run_select: assert property (s_cfg_write |=> shutdown_o == !$past(wr_data_i[0]))
    else $error("run select not applied");
  a_variant_fixed: assert property (s_cfg_read |=> rd_data_o[7:1] == {6'h00, VARIANT})
    else $error("variant readback wrong");
  a_clear_pulse: assert property (1'b1 |=> clear_data_o == $past(wr_en_i
    && wr_addr_i == led_ctrl_pkg::ADDR_CFG && wr_data_i[5])) else $error("clear pulse wrong");
  a_scan_store: assert property (wr_en_i && wr_addr_i == led_ctrl_pkg::ADDR_SCAN
    |=> scan_limit_o == $past(wr_data_i[1:0])) else $error("scan limit not stored");
  a_group_pairs: assert property (seg_group_en_o[3:0] == seg_group_en_o[7:4]
    && (digit_drive_o & ~seg_group_en_o[3:0]) == 4'h0) else $error("segment groups unpaired");
  a_key_mask: assert property (key_sample_en_o == seg_group_en_o)
    else $error("key mask differs from scanned groups");
  a_duty_store: assert property (wr_en_i && wr_addr_i == led_ctrl_pkg::ADDR_DUTY
    |=> duty_o == $past(wr_data_i[5:0])) else $error("intensity not stored");
  a_blank_step: assert property (run_reg <= 63 * STEP_CYCLES)
    else $error("slot lit without dark step");
  a_shutdown_dark: assert property (shutdown_o [*4] |-> digit_drive_o == 4'h0
    && seg_group_en_o == 8'h00) else $error("drive active in shutdown");
endmodule

bind led_display_control_regs led_display_control_regs_chk #(
  .STEP_CYCLES(STEP_CYCLES), .VARIANT(VARIANT)) u_led_display_control_regs_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
  .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .addr_err_o(addr_err_o), .shutdown_o(shutdown_o),
  .scan_limit_o(scan_limit_o), .duty_o(duty_o), .clear_data_o(clear_data_o),
  .digit_drive_o(digit_drive_o), .seg_group_en_o(seg_group_en_o),
  .seg_pwm_on_o(seg_pwm_on_o), .key_sample_en_o(key_sample_en_o));

// ### led_display_control_regs_tb.sv
// Self-checking testbench of the LED display control registers.
`timescale 1ns/10ps
module led_display_control_regs_tb;
  // A short step keeps a slot at 128 cycles.
  localparam int SC = 2;
  logic       clk_i;
  logic       rstn_i;
  logic       wr_en_i;
  logic [7:0] wr_addr_i;
  logic [7:0] wr_data_i;
  logic       rd_en_i;
  logic [7:0] rd_addr_i;
  logic [7:0] rd_data_o;
  logic       rd_valid_o;
  logic       addr_err_o;
  logic       shutdown_o;
  logic [1:0] scan_limit_o;
  logic [5:0] duty_o;
  logic       clear_data_o;
  logic [3:0] digit_drive_o;
  logic [7:0] seg_group_en_o;
  logic       seg_pwm_on_o;
  logic [7:0] key_sample_en_o;
  int         fails;
  int         checked;

  led_display_control_regs #(.STEP_CYCLES(SC), .VARIANT(1'b1)) u_led_display_control_regs (
    .clk_i(clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .addr_err_o(addr_err_o), .shutdown_o(shutdown_o),
    .scan_limit_o(scan_limit_o), .duty_o(duty_o), .clear_data_o(clear_data_o),
    .digit_drive_o(digit_drive_o), .seg_group_en_o(seg_group_en_o),
    .seg_pwm_on_o(seg_pwm_on_o), .key_sample_en_o(key_sample_en_o));

  host_model u_host_model (
    .clk_i(clk_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o), .wr_en_o(wr_en_i),
    .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i), .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Shared tasks
  task automatic test_done;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    u_host_model.rd(addr, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask

  task automatic wait_pwm(input logic val);
    for (int i = 0; i < 400; i++)
    begin
      if (seg_pwm_on_o === val)
        return;
      @(negedge clk_i);
    end
    fails++;
    test_done();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    check({7'h00, shutdown_o}, 8'h01);
    check({4'h0, digit_drive_o}, 8'h00);
    rd_chk(led_ctrl_pkg::ADDR_DUTY, 8'h03);
    rd_chk(led_ctrl_pkg::ADDR_SCAN, 8'h03);
    rd_chk(led_ctrl_pkg::ADDR_CFG, 8'h02);
  endtask

  task automatic t_config;
    logic [7:0] d;
    logic       v;
    u_host_model.wr(led_ctrl_pkg::ADDR_CFG, 8'h21);
    check({7'h00, clear_data_o}, 8'h01);
    check({7'h00, shutdown_o}, 8'h00);
    rd_chk(led_ctrl_pkg::ADDR_CFG, 8'h03);
    u_host_model.wr(led_ctrl_pkg::ADDR_CFG, 8'hdc);
    check({7'h00, clear_data_o}, 8'h00);
    check({7'h00, shutdown_o}, 8'h01);
    rd_chk(led_ctrl_pkg::ADDR_CFG, 8'h02);
    u_host_model.wr(led_ctrl_pkg::ADDR_CFG, 8'h01);
    u_host_model.rd(8'h05, d, v);
    check({7'h00, addr_err_o}, 8'h01);
    check(d, 8'h00);
    u_host_model.wr(8'h00, 8'hff);
    check({7'h00, addr_err_o}, 8'h01);
    rd_chk(led_ctrl_pkg::ADDR_DUTY, 8'h03);
  endtask

  task automatic t_scan;
    logic [7:0] exp;
    logic [3:0] seen;
    for (int k = 0; k < 4; k++)
    begin
      u_host_model.wr(led_ctrl_pkg::ADDR_SCAN, {6'h3f, 2'(k)});
      rd_chk(led_ctrl_pkg::ADDR_SCAN, 8'(k));
      repeat (3 * 64 * SC) @(negedge clk_i);
      seen = 4'h0;
      exp = 8'h00;
      for (int i = 0; i <= k; i++)
        exp = exp | (8'h11 << i);
      repeat ((k + 2) * 64 * SC)
      begin
        seen = seen | digit_drive_o;
        @(negedge clk_i);
      end
      check({4'h0, seen}, {4'h0, exp[3:0]});
      check(seg_group_en_o, exp);
      check(key_sample_en_o, exp);
    end
  endtask

  task automatic t_duty;
    logic [7:0] codes [5] = '{8'h00, 8'h03, 8'h3e, 8'h3f, 8'hc5};
    logic [7:0] e;
    logic [7:0] n;
    foreach (codes[j])
    begin
      u_host_model.wr(led_ctrl_pkg::ADDR_DUTY, codes[j]);
      e = {2'b00, codes[j][5:0]};
      if (e > 8'h3e)
        e = 8'h3e;
      wait_pwm(1'b1);
      wait_pwm(1'b0);
      wait_pwm(1'b1);
      n = 8'h00;
      while (seg_pwm_on_o === 1'b1 && n < 8'hc8)
      begin
        n++;
        @(negedge clk_i);
      end
      check(n, 8'((e + 8'h01) * SC));
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    fails = 0;
    checked = 0;
    rstn_i = 1'b0;
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_reset();
    t_config();
    t_scan();
    t_duty();
    test_done();
  end
endmodule

// ### pwm_gate.sv
// PWM comparator and drive enables for the current multiplex slot.
`timescale 1ns/10ps
module pwm_gate (
  // Slot state
  scan_if.gate                                 sb,
  // Drive enables
  output logic                                 seg_on_o,
  output logic [led_ctrl_pkg::DIGITS-1:0]      digit_on_o,
  output logic [led_ctrl_pkg::GROUPS-1:0]      group_on_o
);

  logic [led_ctrl_pkg::DUTY_W-1:0] duty_eff;

  always_comb
  begin
    // Codes above the cap give the same on time as the cap.
    if (sb.duty > led_ctrl_pkg::DUTY_CAP)
    begin
      duty_eff = led_ctrl_pkg::DUTY_CAP;
    end
    else
    begin
      duty_eff = sb.duty;
    end
    // Last step of every slot stays dark as interdigit blanking.
    seg_on_o   = sb.running && (sb.step <= duty_eff)
                 && (sb.step != led_ctrl_pkg::STEP_LAST);
    digit_on_o = sb.running ? led_ctrl_pkg::digit_onehot(sb.digit) : '0;
    group_on_o = sb.running ? led_ctrl_pkg::group_mask(sb.scan) : '0;
  end

endmodule

// ### scan_if.sv
// Interface carrying the multiplex slot state from the slot timer to its users.
`timescale 1ns/10ps
interface scan_if;
  logic [led_ctrl_pkg::DUTY_W-1:0] step;
  logic [led_ctrl_pkg::SCAN_W-1:0] digit;
  logic [led_ctrl_pkg::SCAN_W-1:0] scan;
  logic [led_ctrl_pkg::DUTY_W-1:0] duty;
  logic                            running;

  modport timer (output step, output digit, output scan, output duty, output running);
  modport gate  (input step, input digit, input scan, input duty, input running);
endinterface

// ### slot_timer.sv
// Step divider, PWM step counter and digit counter with slot-boundary latching.
`timescale 1ns/10ps
module slot_timer #(
  parameter int STEP_CYCLES = led_ctrl_pkg::STEP_CYCLES,
  parameter int DIV_W       = $clog2(STEP_CYCLES + 1)
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  // Requested settings
  input  wire logic                            run_i,
  input  wire logic [led_ctrl_pkg::SCAN_W-1:0] scan_req_i,
  input  wire logic [led_ctrl_pkg::DUTY_W-1:0] duty_req_i,
  // Slot state
  scan_if.timer                                sb
);

  logic [DIV_W-1:0]                div_reg;
  logic [DIV_W-1:0]                div_next;
  logic [led_ctrl_pkg::DUTY_W-1:0] step_reg;
  logic [led_ctrl_pkg::DUTY_W-1:0] step_next;
  logic [led_ctrl_pkg::SCAN_W-1:0] digit_reg;
  logic [led_ctrl_pkg::SCAN_W-1:0] digit_next;
  logic [led_ctrl_pkg::SCAN_W-1:0] scan_reg;
  logic [led_ctrl_pkg::SCAN_W-1:0] scan_next;
  logic [led_ctrl_pkg::DUTY_W-1:0] duty_reg;
  logic [led_ctrl_pkg::DUTY_W-1:0] duty_next;
  logic                            run_reg;
  logic                            tick;

  // ==========================================================================
  // Next state
  always_comb
  begin
    tick       = (div_reg == DIV_W'(STEP_CYCLES - 1));
    div_next   = div_reg;
    step_next  = step_reg;
    digit_next = digit_reg;
    scan_next  = scan_reg;
    duty_next  = duty_reg;
    if (!run_i)
    begin
      // Stopped: no slot is in flight, so settings may follow at once.
      div_next   = '0;
      step_next  = led_ctrl_pkg::STEP_FIRST;
      digit_next = '0;
      scan_next  = scan_req_i;
      duty_next  = duty_req_i;
    end
    else if (tick)
    begin
      div_next = '0;
      if (step_reg == led_ctrl_pkg::STEP_LAST)
      begin
        step_next = led_ctrl_pkg::STEP_FIRST;
        // Wrap against the new limit so a shrink never scans a dropped digit.
        if (digit_reg >= scan_req_i)
        begin
          digit_next = '0;
        end
        else
        begin
          digit_next = digit_reg + 2'h1;
        end
        scan_next = scan_req_i;
        duty_next = duty_req_i;
      end
      else
      begin
        step_next = step_reg + 6'h01;
      end
    end
    else
    begin
      div_next = div_reg + DIV_W'(1);
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_reg   <= '0;
      step_reg  <= led_ctrl_pkg::STEP_FIRST;
      digit_reg <= '0;
      scan_reg  <= led_ctrl_pkg::SCAN_RESET;
      duty_reg  <= led_ctrl_pkg::DUTY_RESET;
      run_reg   <= 1'b0;
    end
    else
    begin
      div_reg   <= div_next;
      step_reg  <= step_next;
      digit_reg <= digit_next;
      scan_reg  <= scan_next;
      duty_reg  <= duty_next;
      run_reg   <= run_i;
    end
  end

  assign sb.step    = step_reg;
  assign sb.digit   = digit_reg;
  assign sb.scan    = scan_reg;
  assign sb.duty    = duty_reg;
  assign sb.running = run_reg & run_i;

endmodule
